// file: flash_program_erase_write_seq.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_regs.svh"
// Contract
// [RULE1] Erase unit is 64 bytes, 32 words
// [RULE2] No single-word erase exists
// [RULE3] Erase block from pointer bits 21:6
// [RULE4] Erase-select bit chooses erase over program
// [RULE5] Software sets selects and write gate first
// [RULE6] Long write needs 55h, AAh, then go
// [RULE7] Core stalls for whole long write
// [RULE8] Internal timer ends each 2 ms cycle
// [RULE9] Program whole 8 or 16 byte block
// [RULE10] One holding register per block byte
// [RULE11] Software fills holders then unlocks
// [RULE12] Holders reset to FFh, also after write
// [RULE13] FFh holder leaves flash byte unchanged
// [RULE14] Partially loaded block is allowed
// [RULE15] Software keeps pointer inside held range
// [RULE16] Software does read-modify-erase-program flow
// [RULE17] Self erase never exceeds one block
// [RULE18] Software masks interrupts around unlock
// [RULE19] Low pointer bits pick holding register
// [RULE20] Program address ignores in-block bits
module flash_program_erase_write_seq #(
  parameter int BLOCK_BYTES = 16,
  parameter int LONG_CYCLES = `LONG_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Core side
  flash_seq_if.seq bus,
  // Flash array side
  output logic [1:0] flash_op_o,
  output logic [21:0] flash_addr_o,
  output logic [BLOCK_BYTES*8-1:0] flash_data_o,
  output logic [BLOCK_BYTES-1:0] flash_byte_en_o,
  output logic flash_busy_o
);
  localparam int IDX_W = $clog2(BLOCK_BYTES);
  localparam int CNT_W = $clog2(LONG_CYCLES + 1);
  flash_seq_pkg::seq_state_type state_reg, state_next;
  logic [7:0] ctrl_reg; // Memory control register
  logic [7:0] latch_reg; // Table byte latch
  logic [21:0] table_pointer_reg; // Table pointer
  logic [7:0] hold_reg [BLOCK_BYTES]; // Holding registers
  logic [CNT_W-1:0] timer_reg; // Programming timer
  logic [1:0] op_reg; // Current operation
  logic [21:0] op_addr_reg; // Latched operation address
  // Decode strobes
  wire wr_ctrl = bus.wr && (bus.addr == `ADDR_MEM_CTRL);
  wire wr_unlock = bus.wr && (bus.addr == `ADDR_UNLOCK);
  wire wr_latch = bus.wr && (bus.addr == `ADDR_TBL_LATCH);
  wire wr_plow = bus.wr && (bus.addr == `ADDR_PTR_LOW);
  wire wr_phigh = bus.wr && (bus.addr == `ADDR_PTR_HIGH);
  wire wr_pupper = bus.wr && (bus.addr == `ADDR_PTR_UPPER);
  wire store_op = bus.wr && (bus.addr == `ADDR_STORE_OP);
  wire key_first = wr_unlock && (bus.wdata == `KEY_FIRST); // First unlock key written
  wire key_second = wr_unlock && (bus.wdata == `KEY_SECOND); // Second unlock key written
  // Start allowed only with program space, no config space, gate set; see [RULE5]
  wire gate_ok = ctrl_reg[`BIT_PGMSEL] && !ctrl_reg[`BIT_CONFIG_SPACE_SELECT] && ctrl_reg[`BIT_WRITE_ENABLE_GATE];
  wire go_req = wr_ctrl && bus.wdata[`BIT_START] && gate_ok;
  wire start = (state_reg == flash_seq_pkg::ST_KEY2) && go_req; // see [RULE6]
  wire done = (state_reg == flash_seq_pkg::ST_BUSY) && (timer_reg == CNT_W'(1)); // see [RULE8]
  // Holding register index from low pointer bits only; see [RULE19]
  wire [IDX_W-1:0] hold_idx = table_pointer_reg[IDX_W-1:0];
  // Unlock sequence state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      flash_seq_pkg::ST_IDLE: begin
        if (key_first) state_next = flash_seq_pkg::ST_KEY1;
      end
      flash_seq_pkg::ST_KEY1: begin
        // Second key must follow directly; a fresh first key restarts; see [RULE6]
        if (key_second) state_next = flash_seq_pkg::ST_KEY2;
        else if (key_first) state_next = flash_seq_pkg::ST_KEY1;
        else if (bus.wr) state_next = flash_seq_pkg::ST_IDLE;
      end
      flash_seq_pkg::ST_KEY2: begin
        // Only go follows; a first key restarts, any other write aborts
        if (start) state_next = flash_seq_pkg::ST_BUSY;
        else if (key_first) state_next = flash_seq_pkg::ST_KEY1;
        else if (bus.wr) state_next = flash_seq_pkg::ST_IDLE;
      end
      flash_seq_pkg::ST_BUSY: begin
        if (done) state_next = flash_seq_pkg::ST_IDLE;
      end
      default: state_next = flash_seq_pkg::ST_IDLE;
    endcase
  end
  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) state_reg <= flash_seq_pkg::ST_IDLE;
    else state_reg <= state_next;
  end
  // Control register; start bit reads high while busy
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg <= 8'h00;
    end else if (done) begin
      ctrl_reg[`BIT_START] <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_reg <= bus.wdata;
      ctrl_reg[`BIT_START] <= start;
    end
  end
  // Table latch and pointer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      latch_reg <= 8'h00;
      table_pointer_reg <= 22'h000000;
    end else begin
      if (wr_latch) latch_reg <= bus.wdata;
      if (wr_plow) table_pointer_reg[7:0] <= bus.wdata;
      if (wr_phigh) table_pointer_reg[15:8] <= bus.wdata;
      if (wr_pupper) table_pointer_reg[21:16] <= bus.wdata[5:0];
    end
  end
  // Holding registers: short writes never touch flash; see [RULE10] [RULE14]
  genvar gi;
  generate
    for (gi = 0; gi < BLOCK_BYTES; gi++) begin : g_hold
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) hold_reg[gi] <= `HOLD_RESET; // see [RULE12]
        else if (done && op_reg == flash_seq_pkg::OP_PROGRAM_TYPE) hold_reg[gi] <= `HOLD_RESET; // see [RULE12]
        else if (store_op && hold_idx == IDX_W'(gi)) hold_reg[gi] <= latch_reg;
      end
      assign flash_data_o[gi*8 +: 8] = hold_reg[gi]; // see [RULE9]
      // FFh bytes are not driven into the array; see [RULE13]
      assign flash_byte_en_o[gi] = (op_reg == flash_seq_pkg::OP_PROGRAM_TYPE)
                                   && (hold_reg[gi] != 8'hFF);
    end
  endgenerate
  // Operation, address latch and programming timer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_reg <= flash_seq_pkg::OP_IDLE_TYPE;
      op_addr_reg <= 22'h000000;
      timer_reg <= '0;
    end else if (start) begin
      timer_reg <= CNT_W'(LONG_CYCLES);
      if (ctrl_reg[`BIT_ERASE] || bus.wdata[`BIT_ERASE]) begin // see [RULE4]
        op_reg <= flash_seq_pkg::OP_ERASE_TYPE;
        // One 64-byte block only, low six bits cleared; see [RULE1] [RULE2] [RULE3] [RULE17]
        op_addr_reg <= {table_pointer_reg[21:6], 6'h00};
      end else begin
        op_reg <= flash_seq_pkg::OP_PROGRAM_TYPE;
        // In-block bits dropped; see [RULE20] [RULE15]
        op_addr_reg <= {table_pointer_reg[21:IDX_W], IDX_W'(0)};
      end
    end else if (done) begin
      op_reg <= flash_seq_pkg::OP_IDLE_TYPE;
      timer_reg <= '0;
    end else if (state_reg == flash_seq_pkg::ST_BUSY) begin
      timer_reg <= timer_reg - CNT_W'(1); // see [RULE8]
    end
  end
  assign flash_op_o = op_reg;
  assign flash_addr_o = op_addr_reg;
  assign flash_busy_o = (state_reg == flash_seq_pkg::ST_BUSY);
  assign bus.stall = (state_reg == flash_seq_pkg::ST_BUSY); // see [RULE7]
  // Read mux; software verifies by reading back; see [RULE16]
  wire [7:0] status_byte = {6'h00, state_reg};
  assign bus.rdata = !bus.rd ? 8'h00 :
                     (bus.addr == `ADDR_MEM_CTRL) ? ctrl_reg :
                     (bus.addr == `ADDR_TBL_LATCH) ? latch_reg :
                     (bus.addr == `ADDR_PTR_LOW) ? table_pointer_reg[7:0] :
                     (bus.addr == `ADDR_PTR_HIGH) ? table_pointer_reg[15:8] :
                     (bus.addr == `ADDR_PTR_UPPER) ? {2'h0, table_pointer_reg[21:16]} :
                     (bus.addr == `ADDR_STATUS) ? status_byte : 8'h00;
endmodule : flash_program_erase_write_seq
`default_nettype wire

// file: flash_seq_regs.svh
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH
// Core-side special register addresses (designer's map)
`define ADDR_MEM_CTRL 4'h0
`define ADDR_UNLOCK 4'h1
`define ADDR_TBL_LATCH 4'h2
`define ADDR_PTR_LOW 4'h3
`define ADDR_PTR_HIGH 4'h4
`define ADDR_PTR_UPPER 4'h5
`define ADDR_STATUS 4'h6
`define ADDR_STORE_OP 4'h7
// Memory control register bit positions
`define BIT_START 1
`define BIT_WRITE_ENABLE_GATE 2
`define BIT_ERASE 4
`define BIT_CONFIG_SPACE_SELECT 6
`define BIT_PGMSEL 7
// Unlock key bytes
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
// Holding register reset value
`define HOLD_RESET 8'hFF
// Long write duration in microseconds and clock rate in MHz
`define LONG_WRITE_US 2000
`define CLK_MHZ 10
`define LONG_WRITE_CYCLES (`LONG_WRITE_US * `CLK_MHZ)
`endif

// file: flash_seq_pkg.sv
`default_nettype none
package flash_seq_pkg;
  // Operation kinds sent to the flash array
  typedef enum logic [1:0] {
    OP_IDLE_TYPE = 2'b00,
    OP_ERASE_TYPE = 2'b01,
    OP_PROGRAM_TYPE = 2'b10
  } flash_op_type;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_KEY1 = 2'b01,
    ST_KEY2 = 2'b10,
    ST_BUSY = 2'b11
  } seq_state_type;
endpackage : flash_seq_pkg
`default_nettype wire

// file: flash_seq_if.sv
`timescale 1ns/100ps
`default_nettype none
interface flash_seq_if;
  // Core bus to the sequencer
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  // Stall back to the core
  logic stall;
  modport seq (input addr, input wdata, input wr, input rd, output rdata, output stall);
  modport core (output addr, output wdata, output wr, output rd, input rdata, input stall);
endinterface : flash_seq_if
`default_nettype wire

// file: flash_core_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_regs.svh"
// Core end: turns software register accesses into sequencer bus cycles
module flash_core_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Software port
  input wire logic [3:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o,
  output logic sw_stall_o,
  // Link to sequencer
  flash_seq_if.core bus
);
  logic [7:0] rdata_reg; // Captured read data
  // Software keeps interrupts off and sets select bits; see [RULE5] [RULE11] [RULE18]
  assign bus.addr = sw_addr_i;
  assign bus.wdata = sw_wdata_i;
  // Accesses are withheld while the core is stalled; see [RULE7]
  assign bus.wr = sw_wr_i & ~bus.stall;
  assign bus.rd = sw_rd_i & ~bus.stall;
  assign sw_stall_o = bus.stall;
  // Read data one cycle after the strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= bus.rdata;
    end
  end
  assign sw_rdata_o = rdata_reg;
endmodule : flash_core_port
`default_nettype wire

// file: flash_seq_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_regs.svh"
// Watches the link between the core end and the sequencer
module flash_seq_chk #(
  parameter int LONG_CYCLES = `LONG_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Link signals
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic stall
);
  int stall_cnt_reg; // Consecutive stall cycles seen so far
  logic [11:0] hist1_reg; // Last accepted write
  logic [11:0] hist2_reg; // Write before that
  logic [7:0] ctrl_reg; // Stored control byte
  // Shadow the accepted writes and count stall cycles
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stall_cnt_reg <= 0;
      hist1_reg <= 12'h000;
      hist2_reg <= 12'h000;
      ctrl_reg <= 8'h00;
    end else begin
      stall_cnt_reg <= stall ? stall_cnt_reg + 1 : 0;
      if (wr && !stall) begin
        hist1_reg <= {addr, wdata};
        hist2_reg <= hist1_reg;
        if (addr == `ADDR_MEM_CTRL) ctrl_reg <= wdata;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_keys_then_go: assert property (wr && !stall && addr == `ADDR_MEM_CTRL
    && wdata[`BIT_START] && ctrl_reg[`BIT_WRITE_ENABLE_GATE] && ctrl_reg[`BIT_PGMSEL]
    && !ctrl_reg[`BIT_CONFIG_SPACE_SELECT] && hist1_reg == {`ADDR_UNLOCK, `KEY_SECOND}
    && hist2_reg == {`ADDR_UNLOCK, `KEY_FIRST} |=> stall)
    else $error("unlocked go did not stall");
  a_go_after_keys: assert property ($rose(stall) |-> $past(wr)
    && $past(addr) == `ADDR_MEM_CTRL && $past(hist1_reg) == {`ADDR_UNLOCK, `KEY_SECOND}
    && $past(hist2_reg) == {`ADDR_UNLOCK, `KEY_FIRST})
    else $error("stall began without unlock");
  a_go_needs_gate: assert property ($rose(stall) |-> $past(ctrl_reg[`BIT_WRITE_ENABLE_GATE])
    && $past(ctrl_reg[`BIT_PGMSEL]) && !$past(ctrl_reg[`BIT_CONFIG_SPACE_SELECT]))
    else $error("stall began without gate bits");
  a_stall_max: assert property (stall |-> stall_cnt_reg < LONG_CYCLES)
    else $error("stall too long");
  a_stall_full: assert property ($fell(stall) |-> stall_cnt_reg == LONG_CYCLES)
    else $error("stall ended early");
  a_stall_hold: assert property ($rose(stall) |-> stall [*8])
    else $error("stall dropped at start");
  a_stall_gates: assert property (stall |-> !wr && !rd)
    else $error("strobe passed during stall");
  a_rdata_idle: assert property (!rd |-> rdata == 8'h00)
    else $error("read data without read");
endmodule : flash_seq_chk
`default_nettype wire

// file: flash_program_erase_write_seq_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_regs.svh"
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module flash_program_erase_write_seq_bench;
  localparam int BB = 8; // Write block bytes
  localparam int LC = 20; // Shortened long write
  logic clk_i, nrst_i, sw_wr_i, sw_rd_i, sw_stall_o, flash_busy_o;
  logic [3:0] sw_addr_i;
  logic [7:0] sw_wdata_i, sw_rdata_o, rd_val;
  logic [1:0] flash_op_o;
  logic [21:0] flash_addr_o;
  logic [BB*8-1:0] flash_data_o, exp_data;
  logic [BB-1:0] flash_byte_en_o, exp_en;
  int num_errors = 0;
  int n_compared = 0;
  int k;
  // Holding loads: pointer low byte, latch value, holder index it should land in
  logic [7:0] rows [3][3] = '{'{8'h23, 8'h12, 8'h03}, '{8'hF8, 8'h00, 8'h00},
    '{8'h0E, 8'hFF, 8'h06}};
  flash_seq_if sif ();
  flash_core_port flash_core_port_inst (.clk_i(clk_i), .nrst_i(nrst_i), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
    .sw_stall_o(sw_stall_o), .bus(sif.core));
  flash_program_erase_write_seq #(.BLOCK_BYTES(BB), .LONG_CYCLES(LC))
    flash_program_erase_write_seq_inst (.clk_i(clk_i), .nrst_i(nrst_i), .bus(sif.seq),
    .flash_op_o(flash_op_o), .flash_addr_o(flash_addr_o), .flash_data_o(flash_data_o),
    .flash_byte_en_o(flash_byte_en_o), .flash_busy_o(flash_busy_o));
  flash_seq_chk #(.LONG_CYCLES(LC)) flash_seq_chk_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .addr(sif.addr), .wdata(sif.wdata), .wr(sif.wr), .rd(sif.rd), .rdata(sif.rdata),
    .stall(sif.stall));
  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // One write cycle, then one idle cycle
  task wr(input logic [3:0] a, input logic [7:0] d);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge clk_i);
    sw_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  // One read cycle, data taken in the cycle after
  task rd(input logic [3:0] a);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge clk_i);
    sw_rd_i <= 1'b0;
    #1 rd_val = sw_rdata_o;
    @(posedge clk_i);
  endtask : rd
  // Control setup, unlock keys, then go
  task run_long(input logic [7:0] ctrl);
    wr(`ADDR_MEM_CTRL, ctrl);
    wr(`ADDR_UNLOCK, `KEY_FIRST);
    wr(`ADDR_UNLOCK, `KEY_SECOND);
    wr(`ADDR_MEM_CTRL, ctrl | 8'h02);
  endtask : run_long
  // Bounded wait for the long write to end
  task wait_idle;
    for (int i = 0; i < 40 && flash_busy_o !== 1'b0; i++) @(posedge clk_i);
    `CHK("busy end", 1'b0, flash_busy_o)
  endtask : wait_idle
  // Counts and verdict
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Watchdog
  initial begin
    #(1000 * 100);
    num_errors++;
    test_done();
  end
  initial begin
    {nrst_i, sw_wr_i, sw_rd_i, sw_addr_i, sw_wdata_i} = '0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    `CHK("reset data", {BB{8'hFF}}, flash_data_o)
    `CHK("reset op", 2'h0, flash_op_o)
    $display("reset test done");
    exp_data = {BB{8'hFF}};
    exp_en = '0;
    foreach (rows[i]) begin
      wr(`ADDR_TBL_LATCH, rows[i][1]);
      wr(`ADDR_PTR_LOW, rows[i][0]);
      wr(`ADDR_STORE_OP, 8'h00);
      k = rows[i][2];
      `CHK("holder byte", rows[i][1], flash_data_o[8*k+:8])
      exp_data[8*k+:8] = rows[i][1];
      exp_en[k] = rows[i][1] !== 8'hFF;
    end
    `CHK("holders", exp_data, flash_data_o)
    $display("holder test done");
    // Pointer kept inside the held block before go
    wr(`ADDR_PTR_UPPER, 8'h01);
    wr(`ADDR_PTR_HIGH, 8'h34);
    wr(`ADDR_PTR_LOW, 8'h25);
    run_long(8'h84);
    `CHK("stall", 1'b1, sw_stall_o)
    `CHK("prog op", 2'h2, flash_op_o)
    `CHK("prog addr", 22'h013420, flash_addr_o)
    `CHK("prog enables", exp_en, flash_byte_en_o)
    `CHK("prog data", exp_data, flash_data_o)
    wait_idle();
    `CHK("holders cleared", {BB{8'hFF}}, flash_data_o)
    rd(`ADDR_MEM_CTRL);
    `CHK("go bit", 1'b0, rd_val[1])
    $display("program test done");
    // Block erase of the same area, as in the update flow
    wr(`ADDR_PTR_LOW, 8'h3F);
    run_long(8'h94);
    `CHK("erase op", 2'h1, flash_op_o)
    `CHK("erase addr", 22'h013400, flash_addr_o)
    `CHK("erase enables", {BB{1'b0}}, flash_byte_en_o)
    wait_idle();
    $display("erase test done");
    wr(`ADDR_UNLOCK, `KEY_FIRST);
    wr(`ADDR_TBL_LATCH, 8'h00);
    wr(`ADDR_UNLOCK, `KEY_SECOND);
    wr(`ADDR_MEM_CTRL, 8'h86);
    `CHK("broken keys", 1'b0, flash_busy_o)
    run_long(8'h80);
    `CHK("no gate", 1'b0, flash_busy_o)
    $display("refusal test done");
    // Reset in the middle of a long write
    wr(`ADDR_TBL_LATCH, 8'h5A);
    wr(`ADDR_STORE_OP, 8'h00);
    run_long(8'h84);
    `CHK("second go", 1'b1, flash_busy_o)
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("reset stall", 1'b0, sw_stall_o)
    `CHK("reset holders", {BB{8'hFF}}, flash_data_o)
    `CHK("reset addr", 22'h000000, flash_addr_o)
    nrst_i <= 1'b1;
    @(posedge clk_i);
    // A repeated first key restarts the unlock sequence
    wr(`ADDR_UNLOCK, `KEY_FIRST);
    wr(`ADDR_UNLOCK, `KEY_FIRST);
    rd(`ADDR_STATUS);
    `CHK("repeat first key", 8'h01, rd_val)
    wr(`ADDR_UNLOCK, `KEY_SECOND);
    rd(`ADDR_STATUS);
    `CHK("second key", 8'h02, rd_val)
    $display("mid-run reset test done");
    test_done();
  end
endmodule : flash_program_erase_write_seq_bench
`default_nettype wire
